/* hw/cgr_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - rom address is 6-bit code plus 3-bit line select
// - parallel dot-line word from rom is serialised
// - line select is a binary counter in display order
// - stored codes recirculate output to input in a loop
// - six code bit loops shift together in lockstep
// - serialiser shifts eight times per dot-line word
// - 5-bit dot word becomes five successive beam bits
// - memory split into page section and row section
// - only row section recirculates during row display
// - line select advances when first char returns to output
// - seven recirculations complete one character row
// - row outputs present row characters in order
// - one recirculation spans one horizontal scan
// - dynamic registers never left unclocked too long
// - nine intervals per row: seven scans, two reload
// - zero bits inserted between adjacent characters
module cgr_ctrl
  import cgr_pkg::*;
#(
  parameter int N = `CGR_ROW_CHARS,
  parameter int R = `CGR_PAGE_ROWS
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // character generator rom
  output cgr_addr_t                   rom_addr,
  input  wire logic [`CGR_DOTS-1:0]   rom_dots,
  // beam video
  output logic                        video,
  output logic                        hsync,
  output logic                        row_done,
  // code load
  input  wire logic                   load_en,
  input  wire logic [`CGR_CODE_W-1:0] load_code
);
  localparam int PN = (R - 1) * N;
  localparam int CW = $clog2(N + 1);
  localparam int RW = $clog2(R + 1);
  localparam int IW = 4;

  // refresh memory: page and row sections, one loop per code bit
  logic [`CGR_CODE_W-1:0] page_reg [PN];
  logic [`CGR_CODE_W-1:0] row_reg  [N];
  logic [`CGR_CODE_W-1:0] page_next [PN];
  logic [`CGR_CODE_W-1:0] row_next  [N];
  logic [2:0]             dot_reg, dot_next;
  logic [CW-1:0]          chr_reg, chr_next;
  logic [`CGR_LINE_W-1:0] line_reg, line_next;
  logic [RW-1:0]          rowc_reg, rowc_next;
  logic [IW-1:0]          ivl_reg, ivl_next;
  cgr_state_t             st_reg, st_next;
  cgr_addr_t              addr_reg, addr_next;
  logic                   hs_reg, hs_next;
  logic                   rd_reg, rd_next;
  logic                   fill_valid, fill_ready;
  logic [`CGR_DOTS-1:0]   drain_data;
  logic                   drain_valid, drain_ready;
  logic [`CGR_CELL-1:0]   sh_reg, sh_next;
  logic [2:0]             dotpos_reg, dotpos_next;
  logic                   vid_reg, vid_next;

  function automatic logic [2:0] wrap3(input logic [2:0] v,
                                       input logic [2:0] top);
    wrap3 = (v == top) ? 3'h0 : v + 3'h1;
  endfunction : wrap3

  always_comb
  begin
    for (int i = 0; i < PN; i++)
      page_next[i] = page_reg[i];
    for (int i = 0; i < N; i++)
      row_next[i] = row_reg[i];
    dot_next  = dot_reg;
    chr_next  = chr_reg;
    line_next = line_reg;
    rowc_next = rowc_reg;
    ivl_next  = ivl_reg;
    st_next   = st_reg;
    hs_next   = 1'b0;
    rd_next   = 1'b0;
    addr_next = addr_reg;
    case (st_reg)
      CGR_SCAN:
      begin
        // one character cell per eight dot clocks
        if (fill_ready)
        begin
          dot_next = wrap3(dot_reg, 3'(`CGR_CELL - 1));
          if (dot_reg == 3'(`CGR_CELL - 1))
          begin
            // row loop: output back to input, all six bits in step
            for (int i = 0; i < N - 1; i++)
              row_next[i] = row_reg[i + 1];
            row_next[N - 1] = row_reg[0];
            chr_next = chr_reg + 1'b1;
            if (chr_reg == CW'(N - 1))
            begin
              // first char back at output: one scan line done
              chr_next = '0;
              hs_next  = 1'b1;
              ivl_next = ivl_reg + 1'b1;
              line_next = line_reg + 1'b1;
              if (line_reg == 3'(`CGR_LINES - 1))
              begin
                line_next = '0;
                st_next   = CGR_RELOAD;
                rd_next   = 1'b1;
              end
            end
          end
        end
      end
      CGR_RELOAD:
      begin
        // two short intervals, two clocks per char: old row into page, next row out
        dot_next = wrap3(dot_reg, 3'h1);
        if (dot_reg == 3'h1)
        begin
          if (PN > 0)
          begin
            for (int i = 0; i < N; i++)
              row_next[i] = page_reg[i];
            for (int i = 0; i < PN - N; i++)
              page_next[i] = page_reg[i + N];
            for (int i = 0; i < N; i++)
              page_next[PN - N + i] = row_reg[i];
          end
          chr_next = chr_reg + 1'b1;
          if (chr_reg == CW'(N - 1))
          begin
            chr_next = '0;
            ivl_next = ivl_reg + 1'b1;
            if (ivl_reg == IW'(`CGR_ROW_IVL - 1))
            begin
              ivl_next = '0;
              st_next  = CGR_SCAN;
              rowc_next = (rowc_reg == RW'(R - 1)) ? '0
                        : rowc_reg + 1'b1;
            end
            else
              chr_next = '0;
          end
        end
      end
      CGR_IDLE:
        st_next = CGR_SCAN;
      default:
        st_next = CGR_SCAN;
    endcase
    // reload walks the loop once per interval; cycle page by N per row
    // transfer only once per row, at the start of the first interval
    if (st_reg == CGR_RELOAD && dot_reg == 3'h1 && PN > 0
        && (chr_reg != '0 || ivl_reg != IW'(`CGR_LINES)))
    begin
      for (int i = 0; i < N; i++)
        row_next[i] = row_reg[i];
      for (int i = 0; i < PN; i++)
        page_next[i] = page_reg[i];
    end
    if (load_en)
    begin
      // type-in enters at the row tail
      row_next[N - 1] = load_code;
    end
    addr_next.code = row_next[0];
    addr_next.line = line_next;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < PN; i++)
        page_reg[i] <= '0;
      for (int i = 0; i < N; i++)
        row_reg[i] <= '0;
      dot_reg  <= '0;
      chr_reg  <= '0;
      line_reg <= '0;
      rowc_reg <= '0;
      ivl_reg  <= '0;
      st_reg   <= CGR_SCAN;
      addr_reg <= '0;
      hs_reg   <= 1'b0;
      rd_reg   <= 1'b0;
    end
    else
    begin
      page_reg <= page_next;
      row_reg  <= row_next;
      dot_reg  <= dot_next;
      chr_reg  <= chr_next;
      line_reg <= line_next;
      rowc_reg <= rowc_next;
      ivl_reg  <= ivl_next;
      st_reg   <= st_next;
      addr_reg <= addr_next;
      hs_reg   <= hs_next;
      rd_reg   <= rd_next;
    end
  end

  // dot words captured once per cell
  assign fill_valid = (st_reg == CGR_SCAN) && (dot_reg == 3'h0);

  cgr_fifo #(
    .W (`CGR_DOTS),
    .D (`CGR_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (fill_valid),
    .in_ready  (fill_ready),
    .in_data   (rom_dots),
    .out_valid (drain_valid),
    .out_ready (drain_ready),
    .out_data  (drain_data)
  );

  // serialiser: 5 dots then 3 blank bits per cell
  assign drain_ready = (dotpos_reg == 3'h0);
  always_comb
  begin
    sh_next     = {sh_reg[`CGR_CELL-2:0], 1'b0};
    dotpos_next = dotpos_reg - 3'h1;
    vid_next    = sh_reg[`CGR_CELL-1];
    if (drain_ready)
    begin
      sh_next     = '0;
      dotpos_next = 3'h0;
      vid_next    = 1'b0;
      if (drain_valid)
      begin
        // first dot leaves now, the rest and the blanks follow
        sh_next     = {drain_data[`CGR_DOTS-2:0], 4'h0};
        dotpos_next = 3'(`CGR_CELL - 1);
        vid_next    = drain_data[`CGR_DOTS-1];
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_reg     <= '0;
      dotpos_reg <= '0;
      vid_reg    <= 1'b0;
    end
    else
    begin
      sh_reg     <= sh_next;
      dotpos_reg <= dotpos_next;
      vid_reg    <= vid_next;
    end
  end

  assign rom_addr = addr_reg;
  assign video    = vid_reg;
  assign hsync    = hs_reg;
  assign row_done = rd_reg;

  line_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
    hs_reg |-> line_reg <= 3'h6)
    else $error("line select beyond seventh line");
  line_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    hs_reg && !rd_reg |-> line_reg == $past(line_reg) + 3'h1)
    else $error("line select did not advance");
  addr_line_a: assert property (@(posedge clk) disable iff (!rst_n)
    rom_addr.line == line_reg)
    else $error("rom line address mismatch");
  code_out_a: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(load_en) |-> rom_addr.code == row_reg[0])
    else $error("rom code not from row output");
  row_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_reg |-> st_reg == CGR_RELOAD && line_reg == 3'h0)
    else $error("row end not followed by reload");
  gap_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    dotpos_reg <= 3'h2 |-> !vid_reg)
    else $error("blank gap not zero");
  dot_rate_a: assert property (@(posedge clk) disable iff (!rst_n)
    fill_valid && fill_ready |=> !fill_valid [*7])
    else $error("dot words faster than serialiser");
  row_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg == CGR_SCAN |-> ivl_reg < IW'(`CGR_LINES))
    else $error("scan interval count too high");
endmodule : cgr_ctrl
`default_nettype wire

/* hw/cgr_cfg.svh */
`ifndef CGR_CFG_SVH
`define CGR_CFG_SVH
`define CGR_CODE_W      6
`define CGR_LINE_W      3
`define CGR_DOTS        5
`define CGR_CELL        8
`define CGR_LINES       7
`define CGR_ROW_IVL     9
`define CGR_ROW_CHARS   8
`define CGR_PAGE_ROWS   4
`define CGR_FIFO_DEPTH  8
`endif

/* hw/cgr_pkg.sv */
`include "cgr_cfg.svh"
package cgr_pkg;
  typedef enum logic [2:0] {
    CGR_SCAN   = 3'h1,
    CGR_RELOAD = 3'h2,
    CGR_IDLE   = 3'h4
  } cgr_state_t;
  typedef struct packed {
    logic [`CGR_CODE_W-1:0] code;
    logic [`CGR_LINE_W-1:0] line;
  } cgr_addr_t;
endpackage : cgr_pkg

/* hw/cgr_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module cgr_fifo #(
  parameter int W = 5,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_reg [D];
  logic [AW-1:0] wp_reg, rp_reg;
  logic [AW:0]   cnt_reg;
  logic          wr, rd;
  assign in_ready  = (cnt_reg != D[AW:0]);
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rp_reg];
  assign wr = in_valid & in_ready;
  assign rd = out_valid & out_ready;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (wr)
      begin
        mem_reg[wp_reg] <= in_data;
        wp_reg <= (wp_reg == AW'(D - 1)) ? '0 : wp_reg + 1'b1;
      end
      if (rd)
        rp_reg <= (rp_reg == AW'(D - 1)) ? '0 : rp_reg + 1'b1;
      cnt_reg <= cnt_reg + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
    end
  end
endmodule : cgr_fifo
`default_nettype wire

/* dv/cgr_rom_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cgr_rom_model
  import cgr_pkg::*;
(
  // address from controller
  input  wire cgr_addr_t         rom_addr,
  // dot word back
  output logic [`CGR_DOTS-1:0]   rom_dots
);
  // static rom, answers in the same cycle
  assign rom_dots = rom_addr.code[4:0] ^ {2'h0, rom_addr.line};
endmodule : cgr_rom_model
`default_nettype wire

/* dv/test_cgr_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cgr_cfg.svh"
module test_cgr_ctrl
  import cgr_pkg::*;
();
  localparam int N = `CGR_ROW_CHARS;
  localparam int R = `CGR_PAGE_ROWS;
  logic       clk, rst_n, load_en, video, hsync, row_done;
  logic [5:0] load_code;
  logic [4:0] rom_dots;
  cgr_addr_t  rom_addr;
  int         err_total, n_tests, cyc, ones, run, max_run, rp;

  cgr_ctrl #(.N(N), .R(R)) cgr_ctrl_inst (
    .clk(clk), .rst_n(rst_n), .rom_addr(rom_addr), .rom_dots(rom_dots),
    .video(video), .hsync(hsync), .row_done(row_done),
    .load_en(load_en), .load_code(load_code));
  cgr_rom_model cgr_rom_model_inst (.rom_addr(rom_addr), .rom_dots(rom_dots));

  always #2.5 clk = ~clk;

  // video watched away from the launching edge
  always @(negedge clk)
  begin
    if (video === 1'b1)
    begin
      ones++;
      run++;
    end
    else
      run = 0;
    if (run > max_run)
      max_run = run;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic wait_ev(input bit rd, output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while ((rd ? row_done : hsync) !== 1'b1 && n < 2000);
  endtask : wait_ev

  // one row: scan lines, length, widest gap, optional code check
  task automatic row_stats(output int hs, output int per, output int mg,
                           input bit en, input logic [5:0] k);
    int g;
    hs = 0;
    per = 0;
    mg = 0;
    g = 0;
    ones = 0;
    do
    begin
      @(posedge clk);
      #1;
      per++;
      g++;
      if (hsync === 1'b1)
      begin
        hs++;
        if (g > mg)
          mg = g;
        g = 0;
        if (en)
          check(rom_addr.code, k);
      end
    end
    while (row_done !== 1'b1 && per < 4000);
  endtask : row_stats

  task automatic t_reset();
    repeat (16) @(posedge clk);
    #1;
    check({video, hsync, row_done, rom_addr}, 12'h000);
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    check({video, hsync, row_done, rom_addr}, 12'h000);
  endtask : t_reset

  task automatic t_lines();
    int g;
    for (int i = 1; i < 7; i++)
    begin
      wait_ev(0, g);
      if (i > 1)
        check(g + 2, N * 8);
      repeat (2) @(posedge clk);
      #1;
      check(rom_addr.line, i);
      check(rom_addr.code, 6'h00);
    end
  endtask : t_lines

  task automatic t_rows();
    int g, hs, p2, mg;
    wait_ev(1, g);
    row_stats(hs, rp, mg, 1'b0, 6'h00);
    check(hs, 7);
    row_stats(hs, p2, mg, 1'b0, 6'h00);
    check(p2, rp);
    check(mg <= 3 * N * 8, 1);
  endtask : t_rows

  task automatic t_load();
    int g, hs, p, mg;
    @(posedge clk);
    load_en <= 1'b1;
    load_code <= 6'h1F;
    repeat ((R + 1) * rp) @(posedge clk);
    load_en <= 1'b0;
    wait_ev(1, g);
    max_run = 0;
    for (int r = 0; r <= R; r++)
    begin
      row_stats(hs, p, mg, 1'b1, 6'h1F);
      check(hs, 7);
      check(ones, N * 26);
    end
    check(max_run, 5);
  endtask : t_load

  // dot word buffer seen through video: line 0 cells back to back
  task automatic t_cells();
    logic [7:0] w;
    int         g, lit;
    lit = 0;
    w = 8'h00;
    wait_ev(1, g);
    @(negedge clk);
    while (video !== 1'b1)
      @(negedge clk);
    for (int c = 0; c <= N; c++)
    begin
      for (int b = 0; b < 8; b++)
      begin
        w = {w[6:0], video};
        if (c < N && video === 1'b1)
          lit++;
        @(negedge clk);
      end
      check(w, (c < N) ? 8'hF8 : 8'hF0);
    end
    check(lit, N * 5);
    check(rom_addr.line, 1);
  endtask : t_cells

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    load_en = 1'b0;
    load_code = 6'h00;
    err_total = 0;
    n_tests = 0;
    cyc = 0;
    ones = 0;
    run = 0;
    max_run = 0;
    rp = 0;
    t_reset();
    t_lines();
    t_rows();
    t_load();
    t_cells();
    tally_and_finish();
  end
endmodule : test_cgr_ctrl
`default_nettype wire
